// [logic/msid_consts.svh]
/*
  offsets, field positions and default contents of the identification page
  assumes: included by the package and the register bank
*/
`ifndef MSID_CONSTS_SVH
`define MSID_CONSTS_SVH

// printed byte numbers, kept as register indices; byte address is index * 4
`define MSID_IDX_TYPE 8'h80
`define MSID_IDX_DESC 8'h81
`define MSID_IDX_SUPPLY 8'h82
`define MSID_IDX_MAXTEMP 8'h83
`define MSID_IDX_MINRATE 8'h84
`define MSID_IDX_MAXRATE 8'h85
`define MSID_IDX_WAVE 8'h86
`define MSID_IDX_WTOL 8'h88
`define MSID_IDX_FLAGS 8'h8A
`define MSID_IDX_MONA 8'h8B
`define MSID_IDX_MONB 8'h8C
`define MSID_IDX_CHECK 8'hDF
`define MSID_IDX_FIRST 8'h80
`define MSID_IDX_LAST 8'hDF

// field positions
`define MSID_DESC_PCLASS_HI 7
`define MSID_DESC_PCLASS_LO 6

// masks of implemented bits per byte
`define MSID_MASK_DESC 8'hFE
`define MSID_MASK_SUPPLY 8'hF8
`define MSID_MASK_FLAGS 8'hFC
`define MSID_MASK_MONB 8'hFC

// default contents
`define MSID_DEF_TYPE 8'h00
`define MSID_DEF_DESC 8'h00
`define MSID_DEF_SUPPLY 8'h80
`define MSID_DEF_MAXTEMP 8'h46
`define MSID_DEF_MINRATE 8'h00
`define MSID_DEF_MAXRATE 8'h00
`define MSID_DEF_WAVE 16'h0000
`define MSID_DEF_WTOL 16'h0000
`define MSID_DEF_FLAGS 8'h00
`define MSID_DEF_MONA 8'h00
`define MSID_DEF_MONB 8'h00

`endif

// [logic/msid_pkg.sv]
/*
  types of the identification page
  assumes: msid_consts.svh on the include path
*/
`include "msid_consts.svh"
package msid_pkg;

  typedef enum logic [1:0] {
    PCLASS_1_5W = 2'h0,
    PCLASS_2_0W = 2'h1,
    PCLASS_2_5W = 2'h2,
    PCLASS_3_5W = 2'h3
  } msid_pclass_type;

  // identification contents as a set
  typedef struct packed {
    logic [7:0] type_id;
    logic [7:0] description;
    logic [7:0] supplies;
    logic [7:0] max_temp;
    logic [7:0] min_rate;
    logic [7:0] max_rate;
    logic [15:0] wavelength;
    logic [15:0] wave_tol;
    logic [7:0] flags;
    logic [7:0] mon_a;
    logic [7:0] mon_b;
  } msid_page_type;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } msid_apb_req_type;

  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } msid_apb_rsp_type;

endpackage : msid_pkg

// [logic/msid_page.sv]
/*
  read-only identification page (bytes 128..140 plus checksum at 223)
  behind an APB slave; one byte per aligned word at byte address index*4.
  assumes: APB master, 100 MHz clk_sys, synchronous active-high sys_rst
*/
// Functional notes
// [R1] byte 128 gives module type, 00h if unspecified
// [R2] byte 129 bits 7-6 hold the power class code
// [R3] byte 129 bits 5,4 flag transmit and receive CDR
// [R4] byte 129 bits 3..1 refclock, page 02, controlled launch; bit 0 reserved
// [R5] byte 130 bits 7..3 flag required supplies; bits 2-0 reserved
// [R6] byte 131 maximum case temperature in 1 degree steps
// [R7] byte 132 minimum rate times 100 Mb/s, 00h unknown
// [R8] byte 133 maximum rate times 100 Mb/s, zero unknown
// [R9] bytes 134-135 wavelength field, value/20 nm, zero unused
// [R10] bytes 136-137 tolerance field, value/200 nm, zero unused
// [R11] byte 138 bits 7..4 flag fault, loss and lock flags
// [R12] byte 138 bit 3 flags output squelch on loss of signal
// [R13] byte 138 bit 2 alarm and warning versus alarm only; 1-0 reserved
// [R14] byte 139 bits 7,6 bias and loss-of-power monitors
// [R15] byte 139 bit 5 per-channel receive power monitoring
// [R16] byte 139 bit 4 average power versus modulation amplitude report
// [R17] byte 139 bits 3..0 temperature and elapsed time monitors
// [R18] byte 140 bits 7..2 error ratio, supply and cooler monitors
// [R19] byte 223 holds low eight bits of sum of bytes 128..222
// [R20] all bytes read-only, writes ignored, reserved bits read zero
`timescale 1ns/100ps
`include "msid_consts.svh"
module msid_page (
  // clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // module strap contents
  input wire msid_pkg::msid_page_type id_straps,
  input wire logic id_load,
  // status
  output logic [7:0] checksum,
  output logic write_rejected
);

  ////////////////////////////////////////////////////////////////////////////
  // content store

  msid_pkg::msid_page_type page_q;
  msid_pkg::msid_page_type page_d;
  logic [7:0] sum_q;
  logic [7:0] sum_d;
  logic [31:0] prdata_q;
  logic [31:0] prdata_d;
  logic rej_q;
  logic pslverr_q;

  // reserved bits forced to zero on load
  assign page_d.type_id = id_straps.type_id; // R1
  assign page_d.description = id_straps.description & `MSID_MASK_DESC; // R2 R3 R4
  assign page_d.supplies = id_straps.supplies & `MSID_MASK_SUPPLY; // R5
  assign page_d.max_temp = id_straps.max_temp; // R6
  assign page_d.min_rate = id_straps.min_rate; // R7
  assign page_d.max_rate = id_straps.max_rate; // R8
  assign page_d.wavelength = id_straps.wavelength; // R9
  assign page_d.wave_tol = id_straps.wave_tol; // R10
  assign page_d.flags = id_straps.flags & `MSID_MASK_FLAGS; // R11 R12 R13
  assign page_d.mon_a = id_straps.mon_a; // R14 R15 R16 R17
  assign page_d.mon_b = id_straps.mon_b & `MSID_MASK_MONB; // R18

  // sum over bytes 128..222; the unimplemented ones read zero
  function automatic logic [7:0] page_sum(input msid_pkg::msid_page_type p);
    logic [7:0] s;
    s = 8'h00;
    for (int i = 0; i < 13; i++) begin
      s = s + p[i*8 +: 8];
    end
    return s;
  endfunction : page_sum

  assign sum_d = page_sum(page_d); // R19

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      page_q <= '{`MSID_DEF_TYPE, `MSID_DEF_DESC, `MSID_DEF_SUPPLY, `MSID_DEF_MAXTEMP,
                  `MSID_DEF_MINRATE, `MSID_DEF_MAXRATE, `MSID_DEF_WAVE, `MSID_DEF_WTOL,
                  `MSID_DEF_FLAGS, `MSID_DEF_MONA, `MSID_DEF_MONB};
      sum_q <= 8'h00;
    end else if (id_load) begin
      page_q <= page_d;
      sum_q <= sum_d; // R19
    end
  end

  // sum of the reset contents, computed live from page_q until the first id_load
  logic sum_valid_q;
  logic [7:0] sum_live;
  assign sum_live = page_sum(page_q);

  ////////////////////////////////////////////////////////////////////////////
  // apb decode

  logic [9:0] idx;
  logic aligned;
  logic setup;
  logic [7:0] rd_byte;
  logic mapped;
  assign idx = paddr[11:2];
  assign aligned = (paddr[1:0] == 2'h0);
  assign setup = psel && !penable;

  function automatic logic [8:0] byte_at(input logic [9:0] i,
                                         input msid_pkg::msid_page_type p,
                                         input logic [7:0] s);
    logic [8:0] r;
    r = 9'h000;
    case (i)
      10'(`MSID_IDX_TYPE): r = {1'b1, p.type_id};
      10'(`MSID_IDX_DESC): r = {1'b1, p.description};
      10'(`MSID_IDX_SUPPLY): r = {1'b1, p.supplies};
      10'(`MSID_IDX_MAXTEMP): r = {1'b1, p.max_temp};
      10'(`MSID_IDX_MINRATE): r = {1'b1, p.min_rate};
      10'(`MSID_IDX_MAXRATE): r = {1'b1, p.max_rate};
      10'(`MSID_IDX_WAVE): r = {1'b1, p.wavelength[15:8]};
      10'(`MSID_IDX_WAVE) + 10'h001: r = {1'b1, p.wavelength[7:0]};
      10'(`MSID_IDX_WTOL): r = {1'b1, p.wave_tol[15:8]};
      10'(`MSID_IDX_WTOL) + 10'h001: r = {1'b1, p.wave_tol[7:0]};
      10'(`MSID_IDX_FLAGS): r = {1'b1, p.flags};
      10'(`MSID_IDX_MONA): r = {1'b1, p.mon_a};
      10'(`MSID_IDX_MONB): r = {1'b1, p.mon_b};
      10'(`MSID_IDX_CHECK): r = {1'b1, s};
      default: begin
        // rest of 128..222 reads zero
        if (i >= 10'(`MSID_IDX_FIRST) && i < 10'(`MSID_IDX_LAST)) begin
          r = 9'h100;
        end
      end
    endcase
    return r;
  endfunction : byte_at

  logic [7:0] cur_sum;
  assign cur_sum = sum_valid_q ? sum_q : sum_live;
  assign {mapped, rd_byte} = byte_at(idx, page_q, cur_sum);

  // answer one cycle after setup: data captured during setup
  assign prdata_d = (setup && !pwrite && mapped && aligned) ? {24'h00_0000, rd_byte}
                                                             : 32'h0000_0000;

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      prdata_q <= 32'h0000_0000;
      pslverr_q <= 1'b0;
      rej_q <= 1'b0;
      sum_valid_q <= 1'b0;
    end else begin
      if (setup) begin
        prdata_q <= prdata_d;
        pslverr_q <= pwrite || !mapped || !aligned; // R20
      end
      rej_q <= setup && pwrite; // R20
      if (id_load) begin
        sum_valid_q <= 1'b1;
      end
    end
  end

  assign pready = 1'b1;
  assign prdata = prdata_q;
  assign pslverr = pslverr_q && psel && penable;
  assign checksum = cur_sum;
  assign write_rejected = rej_q;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  property p_read_only;
    @(posedge clk_sys) disable iff (sys_rst)
    (psel && pwrite && !id_load) |=> (page_q == $past(page_q));
  endproperty
  a_read_only: assert property (p_read_only) else $error("page changed on write"); // R20

  property p_write_err;
    @(posedge clk_sys) disable iff (sys_rst)
    (psel && !penable && pwrite) ##1 (psel && penable) |-> pslverr && write_rejected;
  endproperty
  a_write_err: assert property (p_write_err) else $error("write not refused"); // R20

  property p_desc_rsvd;
    @(posedge clk_sys) disable iff (sys_rst) page_q.description[0] == 1'b0;
  endproperty
  a_desc_rsvd: assert property (p_desc_rsvd) else $error("desc bit 0 set"); // R4

  property p_supply_rsvd;
    @(posedge clk_sys) disable iff (sys_rst) page_q.supplies[2:0] == 3'h0;
  endproperty
  a_supply_rsvd: assert property (p_supply_rsvd) else $error("supply reserved set"); // R5

  property p_flags_rsvd;
    @(posedge clk_sys) disable iff (sys_rst) page_q.flags[1:0] == 2'h0;
  endproperty
  a_flags_rsvd: assert property (p_flags_rsvd) else $error("flags reserved set"); // R13

  property p_monb_rsvd;
    @(posedge clk_sys) disable iff (sys_rst) page_q.mon_b[1:0] == 2'h0;
  endproperty
  a_monb_rsvd: assert property (p_monb_rsvd) else $error("monitor reserved set"); // R18

  property p_checksum;
    @(posedge clk_sys) disable iff (sys_rst) id_load |=> checksum == page_sum(page_q);
  endproperty
  a_checksum: assert property (p_checksum) else $error("checksum mismatch"); // R19

  sequence s_read_type;
    psel && !penable && !pwrite && idx == 10'(`MSID_IDX_TYPE) && aligned;
  endsequence
  property p_type_read;
    @(posedge clk_sys) disable iff (sys_rst)
    (s_read_type and ##1 1'b1) ##0 1'b1 |=> prdata == {24'h00_0000, $past(page_q.type_id)};
  endproperty
  a_type_read: assert property (p_type_read) else $error("type byte wrong"); // R1

  property p_wave_read;
    @(posedge clk_sys) disable iff (sys_rst)
    (setup && !pwrite && aligned && idx == 10'(`MSID_IDX_WAVE)) |=>
      prdata[7:0] == $past(page_q.wavelength[15:8]);
  endproperty
  a_wave_read: assert property (p_wave_read) else $error("wavelength byte wrong"); // R9

  // aligned read setup at one word index
  sequence s_rd_at(logic [9:0] k);
    setup && !pwrite && aligned && idx == k;
  endsequence

  property p_desc_read;
    @(posedge clk_sys) disable iff (sys_rst)
    s_rd_at(10'(`MSID_IDX_DESC)) |=>
      prdata == {24'h00_0000, $past(page_q.description)};
  endproperty
  a_desc_read: assert property (p_desc_read) else $error("description byte wrong"); // R2

  property p_supply_read;
    @(posedge clk_sys) disable iff (sys_rst)
    s_rd_at(10'(`MSID_IDX_SUPPLY)) |=>
      prdata == {24'h00_0000, $past(page_q.supplies)};
  endproperty
  a_supply_read: assert property (p_supply_read) else $error("supply byte wrong"); // R5

  property p_maxtemp_read;
    @(posedge clk_sys) disable iff (sys_rst)
    s_rd_at(10'(`MSID_IDX_MAXTEMP)) |=>
      prdata == {24'h00_0000, $past(page_q.max_temp)};
  endproperty
  a_maxtemp_read: assert property (p_maxtemp_read) else $error("max temp byte wrong"); // R6

  property p_minrate_read;
    @(posedge clk_sys) disable iff (sys_rst)
    s_rd_at(10'(`MSID_IDX_MINRATE)) |=>
      prdata == {24'h00_0000, $past(page_q.min_rate)};
  endproperty
  a_minrate_read: assert property (p_minrate_read) else $error("min rate byte wrong"); // R7

  property p_maxrate_read;
    @(posedge clk_sys) disable iff (sys_rst)
    s_rd_at(10'(`MSID_IDX_MAXRATE)) |=>
      prdata == {24'h00_0000, $past(page_q.max_rate)};
  endproperty
  a_maxrate_read: assert property (p_maxrate_read) else $error("max rate byte wrong"); // R8

  property p_wave_lo_read;
    @(posedge clk_sys) disable iff (sys_rst)
    s_rd_at(10'(`MSID_IDX_WAVE) + 10'h001) |=>
      prdata == {24'h00_0000, $past(page_q.wavelength[7:0])};
  endproperty
  a_wave_lo_read: assert property (p_wave_lo_read) else $error("wavelength low wrong"); // R9

  property p_wtol_hi_read;
    @(posedge clk_sys) disable iff (sys_rst)
    s_rd_at(10'(`MSID_IDX_WTOL)) |=>
      prdata == {24'h00_0000, $past(page_q.wave_tol[15:8])};
  endproperty
  a_wtol_hi_read: assert property (p_wtol_hi_read) else $error("tolerance high wrong"); // R10

  property p_wtol_lo_read;
    @(posedge clk_sys) disable iff (sys_rst)
    s_rd_at(10'(`MSID_IDX_WTOL) + 10'h001) |=>
      prdata == {24'h00_0000, $past(page_q.wave_tol[7:0])};
  endproperty
  a_wtol_lo_read: assert property (p_wtol_lo_read) else $error("tolerance low wrong"); // R10

  property p_flags_read;
    @(posedge clk_sys) disable iff (sys_rst)
    s_rd_at(10'(`MSID_IDX_FLAGS)) |=>
      prdata == {24'h00_0000, $past(page_q.flags)};
  endproperty
  a_flags_read: assert property (p_flags_read) else $error("flags byte wrong"); // R11

  property p_mona_read;
    @(posedge clk_sys) disable iff (sys_rst)
    s_rd_at(10'(`MSID_IDX_MONA)) |=>
      prdata == {24'h00_0000, $past(page_q.mon_a)};
  endproperty
  a_mona_read: assert property (p_mona_read) else $error("monitor a byte wrong"); // R14

  property p_monb_read;
    @(posedge clk_sys) disable iff (sys_rst)
    s_rd_at(10'(`MSID_IDX_MONB)) |=>
      prdata == {24'h00_0000, $past(page_q.mon_b)};
  endproperty
  a_monb_read: assert property (p_monb_read) else $error("monitor b byte wrong"); // R18

  property p_check_read;
    @(posedge clk_sys) disable iff (sys_rst)
    s_rd_at(10'(`MSID_IDX_CHECK)) |=>
      prdata == {24'h00_0000, $past(cur_sum)};
  endproperty
  a_check_read: assert property (p_check_read) else $error("check byte wrong"); // R19

  // loading masks reserved bits and keeps the rest
  property p_load_type;
    @(posedge clk_sys) disable iff (sys_rst)
    id_load |=> page_q.type_id == $past(id_straps.type_id);
  endproperty
  a_load_type: assert property (p_load_type) else $error("type not loaded"); // R1

  property p_load_desc;
    @(posedge clk_sys) disable iff (sys_rst)
    id_load |=> page_q.description == ($past(id_straps.description) & `MSID_MASK_DESC);
  endproperty
  a_load_desc: assert property (p_load_desc) else $error("description not loaded"); // R3

  property p_load_supply;
    @(posedge clk_sys) disable iff (sys_rst)
    id_load |=> page_q.supplies == ($past(id_straps.supplies) & `MSID_MASK_SUPPLY);
  endproperty
  a_load_supply: assert property (p_load_supply) else $error("supplies not loaded"); // R5

  property p_load_wave;
    @(posedge clk_sys) disable iff (sys_rst)
    id_load |=> page_q.wavelength == $past(id_straps.wavelength);
  endproperty
  a_load_wave: assert property (p_load_wave) else $error("wavelength not loaded"); // R9

  property p_load_wtol;
    @(posedge clk_sys) disable iff (sys_rst)
    id_load |=> page_q.wave_tol == $past(id_straps.wave_tol);
  endproperty
  a_load_wtol: assert property (p_load_wtol) else $error("tolerance not loaded"); // R10

  property p_load_flags;
    @(posedge clk_sys) disable iff (sys_rst)
    id_load |=> page_q.flags == ($past(id_straps.flags) & `MSID_MASK_FLAGS);
  endproperty
  a_load_flags: assert property (p_load_flags) else $error("flags not loaded"); // R12

  property p_load_mona;
    @(posedge clk_sys) disable iff (sys_rst)
    id_load |=> page_q.mon_a == $past(id_straps.mon_a);
  endproperty
  a_load_mona: assert property (p_load_mona) else $error("monitor a not loaded"); // R16

  property p_load_monb;
    @(posedge clk_sys) disable iff (sys_rst)
    id_load |=> page_q.mon_b == ($past(id_straps.mon_b) & `MSID_MASK_MONB);
  endproperty
  a_load_monb: assert property (p_load_monb) else $error("monitor b not loaded"); // R18

  // bus refusals
  property p_unaligned_err;
    @(posedge clk_sys) disable iff (sys_rst)
    (setup && !aligned) ##1 (psel && penable) |-> pslverr;
  endproperty
  a_unaligned_err: assert property (p_unaligned_err) else $error("unaligned not refused"); // R20

  property p_unmapped_zero;
    @(posedge clk_sys) disable iff (sys_rst)
    (setup && !pwrite && !mapped) |=> prdata == 32'h0000_0000;
  endproperty
  a_unmapped_zero: assert property (p_unmapped_zero) else $error("unmapped data not zero"); // R20

  property p_rej_pulse;
    @(posedge clk_sys) disable iff (sys_rst)
    write_rejected |=> !write_rejected;
  endproperty
  a_rej_pulse: assert property (p_rej_pulse) else $error("refusal pulse too long"); // R20

endmodule : msid_page

// [bench/msid_host.sv]
/*
  host management controller model: APB master doing one transfer per call
  assumes: single clk_sys domain, slave answers with pready in access phase
*/
`timescale 1ns/100ps
module msid_host (
  // clock
  input wire logic clk_sys,
  // apb master side
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [11:0] paddr,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // status seen from the page
  input wire logic write_rejected
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
  end

  //////////////////////////////////////////////////////////////////////////////
  // setup, access until pready, sample at that edge, then release
  task automatic xfer(input logic w, input logic [11:0] a, output logic [31:0] d,
                      output logic err, output logic rej);
    @(posedge clk_sys);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= w ? 32'hA5A5_5A5A : 32'h0000_0000;
    @(posedge clk_sys);
    penable <= 1'b1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    d = prdata;
    err = pslverr;
    rej = write_rejected;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer
endmodule : msid_host

// [bench/module_serial_id_page_bench.sv]
/*
  self-checking bench of the identification page over APB
  assumes: msid_page and msid_host compiled first, 100 MHz clock
*/
`timescale 1ns/100ps
module module_serial_id_page_bench;
  logic clk_sys, sys_rst, psel, penable, pwrite, pready, pslverr, id_load;
  logic write_rejected, e, r;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [7:0] checksum, sum;
  logic [7:0] exp [0:12];
  msid_pkg::msid_page_type id_straps;
  int mismatches = 0;
  int cmp_count = 0;

  msid_page DUT (.clk_sys(clk_sys), .sys_rst(sys_rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .id_straps(id_straps), .id_load(id_load), .checksum(checksum),
    .write_rejected(write_rejected));
  msid_host host (.clk_sys(clk_sys), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .write_rejected(write_rejected));

  //////////////////////////////////////////////////////////////////////////////
  task chk(input logic [31:0] seen, input logic [31:0] want);
    cmp_count++;
    if (seen !== want) begin
      mismatches++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, want);
    end
  endtask : chk

  task end_sim;
    $display("mismatches %0d, compares %0d", mismatches, cmp_count);
    if (mismatches == 0 && cmp_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : end_sim

  // all thirteen bytes, then the check byte
  task page;
    int i;
    sum = 8'h00;
    for (i = 0; i < 13; i++) begin
      host.xfer(1'b0, 12'h200 + 12'(4 * i), rd, e, r);
      chk(rd,
        {24'h00_0000, exp[i]});
      chk({31'h0000_0000, e}, 32'h0000_0000);
      sum = sum + exp[i];
    end
    host.xfer(1'b0, 12'h37C, rd, e, r);
    chk(rd, {24'h00_0000, sum});
    chk({24'h00_0000, checksum}, {24'h00_0000, sum});
  endtask : page

  //////////////////////////////////////////////////////////////////////////////
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  initial begin
    #100000;
    mismatches++;
    end_sim();
  end

  initial begin
    sys_rst = 1'b1;
    id_load = 1'b0;
    id_straps = '0;
    repeat (16) @(posedge clk_sys);
    sys_rst <= 1'b0;
    exp = '{8'h00, 8'h00, 8'h80, 8'h46, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
      8'h00, 8'h00};
    page();
    // all-ones straps on the masked bytes expose reserved-bit masking, big-endian pairs
    @(posedge clk_sys);
    id_straps <= '{8'h11, 8'hFF, 8'hFF, 8'h55, 8'h0A, 8'h3F, 16'h3548, 16'h00C8, 8'hFF,
      8'hA5, 8'hFF};
    id_load <= 1'b1;
    @(posedge clk_sys);
    id_load <= 1'b0;
    exp = '{8'h11, 8'hFE, 8'hF8, 8'h55, 8'h0A, 8'h3F, 8'h35, 8'h48, 8'h00, 8'hC8, 8'hFC,
      8'hA5, 8'hFC};
    page();
    // refused write leaves content
    host.xfer(1'b1, 12'h200, rd, e, r);
    chk({31'h0000_0000, e}, 32'h0000_0001);
    chk({31'h0000_0000, r}, 32'h0000_0001);
    host.xfer(1'b0, 12'h200, rd, e, r);
    chk(rd, 32'h0000_0011);
    // unmapped, unaligned, past the check byte, unused byte 141
    host.xfer(1'b0, 12'h000, rd, e, r);
    chk({31'h0000_0000, e}, 32'h0000_0001);
    chk(rd, 32'h0000_0000);
    host.xfer(1'b0, 12'h201, rd, e, r);
    chk({31'h0000_0000, e}, 32'h0000_0001);
    host.xfer(1'b0, 12'h380, rd, e, r);
    chk({31'h0000_0000, e}, 32'h0000_0001);
    host.xfer(1'b0, 12'h234, rd, e, r);
    chk(rd, 32'h0000_0000);
    chk({31'h0000_0000, e}, 32'h0000_0000);
    end_sim();
  end
endmodule : module_serial_id_page_bench
